// [mic_core_model.sv]
`timescale 1ns/1ps
module mic_core_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        asleep,
  input  wire logic        pc_load,
  input  wire logic [12:0] pc_load_value,
  output logic             instr_cycle,
  output logic             instr_done,
  output logic [12:0]      pc_current
);
  logic [1:0] q_cnt;
  logic       odd;
  // ==========================================================
  // one instruction cycle every four clocks, frozen in sleep
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_cnt       <= 2'h0;
      odd         <= 1'b0;
      instr_cycle <= 1'b0;
      instr_done  <= 1'b0;
      pc_current  <= 13'h0000;
    end else begin
      if (!asleep) q_cnt <= q_cnt + 2'h1;
      instr_cycle <= !asleep && q_cnt == 2'h3;
      instr_done  <= !asleep && q_cnt == 2'h3 && (!slow || odd);
      if (!asleep && q_cnt == 2'h3) odd <= !odd;
      if (pc_load) pc_current <= pc_load_value;
      else if (instr_done) pc_current <= pc_current + 13'h0001;
    end
  end
endmodule : mic_core_model

// [mic_irq_ctrl.sv]
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Global enable set lets unmasked requests interrupt; clear blocks all.
// - Reset clears the global enable.
// - Return-from-interrupt leaves the routine and sets the global enable.
// - Servicing clears global enable, pushes return address, loads vector 0004h.
// - External events are serviced three or four instruction cycles later.
// - Latency is independent of one- or two-cycle instructions; here a two-cycle one can add an instruction cycle.
// - Flags set on events regardless of the interrupt enable bits.
// - Request pending when global enable is cleared stays pending until re-enabled.
// - Every request has its own enable bit.
// - Core control holds edge-pin, port-change, timer-zero flags and enables.
// - First peripheral register holds converter, serial, timer, capture flags.
// - Second peripheral register holds clock-monitor, comparator, write, wake flags.
// - Wake by interrupt runs PC+1, then vectors to 0004h if enabled.
// - External pin is edge sensitive, polarity chosen by edge select.
// - Enabled change pins mismatching the last port read set port-change flag.
module mic_irq_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        ext_irq_pin,
  input  wire logic [7:0]  change_detect_port,
  // peripheral event pulses (same clock)
  input  wire logic        tmr0_ovf_evt,
  input  wire logic [7:0]  periph_one_evt,
  input  wire logic [7:0]  periph_two_evt,
  // core sequencer
  input  wire logic        instr_cycle,
  input  wire logic        instr_done,
  input  wire logic        ret_from_irq,
  input  wire logic        sleep_req,
  input  wire logic [12:0] pc_current,
  output logic             irq_request,
  output logic             pc_load,
  output logic [12:0]      pc_load_value,
  output logic             stack_push,
  output logic [12:0]      stack_push_data,
  output logic             core_wake,
  output logic             core_asleep
);

  typedef struct packed {
    mic_pkg::mic_state_t st;
    logic [7:0]          core_ctrl;
    logic [7:0]          preq_one;
    logic [7:0]          preq_two;
    logic [7:0]          pen_one;
    logic [7:0]          pen_two;
    logic [8:0]          option;
    logic [7:0]          port_latch;
    logic                ext_prev;
    logic                aw_got;
    logic [7:0]          aw_addr;
    logic                w_got;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                irq_req;
    logic                pc_load;
    logic [12:0]         pc_val;
    logic                push;
    logic [12:0]         push_data;
    logic                wake;
    logic                asleep;
  } mic_state_s_t;

  mic_state_s_t state_reg;
  mic_state_s_t state_next;

  logic       ext_sync;
  logic [7:0] port_sync;

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  mic_sync #(.WIDTH(9)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({ext_irq_pin, change_detect_port}),
    .sync_out ({ext_sync, port_sync})
  );

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic       ext_edge;
    logic       port_mismatch;
    logic       pending;
    logic       do_write;
    logic       wr_hit;
    logic       rd_port;
    logic [7:0] wb;
    logic [7:0] set_cc;
    logic [7:0] set_one;
    logic [7:0] set_two;
    ext_edge      = 1'b0;
    port_mismatch = 1'b0;
    pending       = 1'b0;
    do_write      = 1'b0;
    wr_hit        = 1'b0;
    rd_port       = 1'b0;
    wb            = 8'h00;
    set_cc        = 8'h00;
    set_one       = 8'h00;
    set_two       = 8'h00;
    state_next    = state_reg;
    state_next.pc_load = 1'b0;
    state_next.push    = 1'b0;
    state_next.wake    = 1'b0;

    // event detection
    ext_edge = state_reg.option[mic_pkg::OPT_EDGE] ? (ext_sync & ~state_reg.ext_prev)
                                                   : (~ext_sync & state_reg.ext_prev);
    state_next.ext_prev = ext_sync;
    port_mismatch = |((port_sync ^ state_reg.port_latch)
                      & state_reg.option[mic_pkg::OPT_IOC_MSB:0]);
    set_cc[mic_pkg::CC_EXT_IRQ_FLAG] = ext_edge;
    set_cc[mic_pkg::CC_PORT_CHANGE_FLAG] = port_mismatch;
    set_cc[mic_pkg::CC_T0IF] = tmr0_ovf_evt;
    set_one = periph_one_evt;
    set_two = periph_two_evt & mic_pkg::PREQ_TWO_MASK;

    // ---------------- axi write channel ----------------
    state_next.awready = 1'b0;
    state_next.wready  = 1'b0;
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_got  = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_got  = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (!state_next.aw_got && !state_reg.bvalid && !state_reg.awready) begin
      state_next.awready = 1'b1;
    end
    if (!state_next.w_got && !state_reg.bvalid && !state_reg.wready) begin
      state_next.wready = 1'b1;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      do_write          = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      wr_hit = (state_reg.aw_addr <= mic_pkg::ADDR_OPTION) && (state_reg.aw_addr[1:0] == 2'b00);
      state_next.bresp = wr_hit ? mic_pkg::RESP_OKAY : mic_pkg::RESP_SLVERR;
    end
    wb = state_reg.w_data[7:0];
    if (do_write && wr_hit && state_reg.w_strb[0]) begin
      case (state_reg.aw_addr)
        mic_pkg::ADDR_CORE_CTRL: state_next.core_ctrl = wb;
        mic_pkg::ADDR_PREQ_ONE:  state_next.preq_one  = wb;
        mic_pkg::ADDR_PREQ_TWO:  state_next.preq_two  = wb & mic_pkg::PREQ_TWO_MASK;
        mic_pkg::ADDR_PEN_ONE:   state_next.pen_one   = wb;
        mic_pkg::ADDR_PEN_TWO:   state_next.pen_two   = wb & mic_pkg::PREQ_TWO_MASK;
        mic_pkg::ADDR_OPTION:    state_next.option[7:0] = wb;
        default: ;
      endcase
    end
    // the edge select sits in the second byte lane
    if (do_write && wr_hit && state_reg.w_strb[1]
        && state_reg.aw_addr == mic_pkg::ADDR_OPTION) begin
      state_next.option[mic_pkg::OPT_EDGE] = state_reg.w_data[mic_pkg::OPT_EDGE];
    end

    // ---------------- axi read channel ----------------
    state_next.arready = 1'b0;
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (!state_reg.rvalid && !state_reg.arready && s_axi_arvalid) begin
      state_next.arready = 1'b1;
    end
    if (state_reg.arready && s_axi_arvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = mic_pkg::RESP_OKAY;
      state_next.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        mic_pkg::ADDR_CORE_CTRL: state_next.rdata[7:0] = state_reg.core_ctrl;
        mic_pkg::ADDR_PREQ_ONE:  state_next.rdata[7:0] = state_reg.preq_one;
        mic_pkg::ADDR_PREQ_TWO:  state_next.rdata[7:0] = state_reg.preq_two;
        mic_pkg::ADDR_PEN_ONE:   state_next.rdata[7:0] = state_reg.pen_one;
        mic_pkg::ADDR_PEN_TWO:   state_next.rdata[7:0] = state_reg.pen_two;
        mic_pkg::ADDR_OPTION:    state_next.rdata[8:0] = state_reg.option;
        mic_pkg::ADDR_STATUS:    state_next.rdata[3:0] = state_reg.st;
        mic_pkg::ADDR_PORT: begin
          state_next.rdata[7:0] = port_sync;
          rd_port = 1'b1;
        end
        default: state_next.rresp = mic_pkg::RESP_SLVERR;
      endcase
    end
    // a port read refreshes the comparison latch, ending the mismatch
    if (rd_port) begin
      state_next.port_latch = port_sync;
    end

    // hardware sets win over software clears
    state_next.core_ctrl = state_next.core_ctrl | set_cc;
    state_next.preq_one  = state_next.preq_one | set_one;
    state_next.preq_two  = state_next.preq_two | set_two;

    // ---------------- request combine ----------------
    pending = |(state_reg.core_ctrl[mic_pkg::CC_T0IF:mic_pkg::CC_PORT_CHANGE_FLAG]
                & state_reg.core_ctrl[mic_pkg::CC_T0IE:mic_pkg::CC_RBIE])
              | (state_reg.core_ctrl[mic_pkg::CC_PEIE]
                 & |((state_reg.preq_one & state_reg.pen_one)
                     | (state_reg.preq_two & state_reg.pen_two)));
    state_next.irq_req = pending & state_next.core_ctrl[mic_pkg::CC_GIE];

    // ---------------- sequencer ----------------
    case (state_reg.st)
      mic_pkg::ST_RUN: begin
        if (ret_from_irq && instr_done) begin
          state_next.core_ctrl[mic_pkg::CC_GIE] = 1'b1;
        end
        // a gie clear this cycle masks the request; it stays pending
        if (pending && state_next.core_ctrl[mic_pkg::CC_GIE]
            && state_reg.core_ctrl[mic_pkg::CC_GIE]) begin
          state_next.st = mic_pkg::ST_SYNC;
        end else if (sleep_req && instr_done) begin
          state_next.st     = mic_pkg::ST_SLEEP;
          state_next.asleep = 1'b1;
        end
      end
      mic_pkg::ST_SYNC: begin
        // wait for the instruction boundary, whatever its length
        if (!(pending && state_next.core_ctrl[mic_pkg::CC_GIE])) begin
          state_next.st = mic_pkg::ST_RUN;
        end else if (instr_done && instr_cycle) begin
          state_next.st = mic_pkg::ST_VEC;
        end
      end
      mic_pkg::ST_VEC: begin
        state_next.core_ctrl[mic_pkg::CC_GIE] = 1'b0;
        state_next.push      = 1'b1;
        state_next.push_data = pc_current;
        state_next.pc_load   = 1'b1;
        state_next.pc_val    = mic_pkg::IRQ_VECTOR;
        state_next.irq_req   = 1'b0;
        state_next.st        = mic_pkg::ST_RUN;
      end
      mic_pkg::ST_SLEEP: begin
        if (pending) begin
          // resume at pc+1; vectoring then follows from run if enabled
          state_next.wake    = 1'b1;
          state_next.asleep  = 1'b0;
          state_next.pc_load = 1'b1;
          state_next.pc_val  = pc_current + mic_pkg::PC_ONE;
          state_next.st      = mic_pkg::ST_RUN;
        end
      end
      default: state_next.st = mic_pkg::ST_RUN;
    endcase
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= '0;
      state_reg.st <= mic_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready   = state_reg.awready;
  assign s_axi_wready    = state_reg.wready;
  assign s_axi_bvalid    = state_reg.bvalid;
  assign s_axi_bresp     = state_reg.bresp;
  assign s_axi_arready   = state_reg.arready;
  assign s_axi_rvalid    = state_reg.rvalid;
  assign s_axi_rdata     = state_reg.rdata;
  assign s_axi_rresp     = state_reg.rresp;
  assign irq_request     = state_reg.irq_req;
  assign pc_load         = state_reg.pc_load;
  assign pc_load_value   = state_reg.pc_val;
  assign stack_push      = state_reg.push;
  assign stack_push_data = state_reg.push_data;
  assign core_wake       = state_reg.wake;
  assign core_asleep     = state_reg.asleep;

endmodule : mic_irq_ctrl

// [mic_irq_ctrl_assertions.sv]
`timescale 1ns/1ps
module mic_irq_ctrl_assertions (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        instr_cycle,
  input wire logic        instr_done,
  input wire logic        irq_request,
  input wire logic        pc_load,
  input wire logic [12:0] pc_load_value,
  input wire logic        stack_push,
  input wire logic        core_wake,
  input wire logic        core_asleep
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // assertions
  rst_quiet_a: assert property ($rose(rst_n) |-> !irq_request && !pc_load)
    else $error("request or load right after reset");
  vec_load_a: assert property (stack_push |-> pc_load && pc_load_value == 13'h0004)
    else $error("push without vector load");
  push_pulse_a: assert property (stack_push |=> !stack_push)
    else $error("push held too long");
  gie_drop_a: assert property (stack_push |-> ##[1:3] !irq_request)
    else $error("request stays after servicing");
  push_cause_a: assert property (stack_push |-> $past(irq_request))
    else $error("vector without request");
  instr_edge_a: assert property (stack_push |->
    $past(instr_cycle && instr_done) || $past(instr_cycle && instr_done, 2))
    else $error("vector not at instruction end");
  sleep_quiet_a: assert property (core_asleep |-> !stack_push)
    else $error("vector while asleep");
  wake_load_a: assert property (core_wake |-> ##[0:2] pc_load)
    else $error("wake without pc load");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (stack_push);
  cover property (core_wake);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : mic_irq_ctrl_assertions

bind mic_irq_ctrl mic_irq_ctrl_assertions u_chk (.core_clk, .rst_n, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .instr_cycle, .instr_done,
  .irq_request, .pc_load, .pc_load_value, .stack_push, .core_wake, .core_asleep);

// [mic_pkg.sv]
package mic_pkg;

  // ==========================================================================
  // register offsets (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h00;   // core_irq_control
  localparam logic [7:0] ADDR_PREQ_ONE  = 8'h04;   // periph_request_one
  localparam logic [7:0] ADDR_PREQ_TWO  = 8'h08;   // periph_request_two
  localparam logic [7:0] ADDR_PEN_ONE   = 8'h0C;   // periph_enable_one
  localparam logic [7:0] ADDR_PEN_TWO   = 8'h10;   // periph_enable_two
  localparam logic [7:0] ADDR_OPTION    = 8'h14;   // edge select, change-pin enables
  localparam logic [7:0] ADDR_STATUS    = 8'h18;   // state readback
  localparam logic [7:0] ADDR_PORT      = 8'h1C;   // change_detect_port read

  // ==========================================================================
  // core_irq_control fields
  // ==========================================================================
  localparam int CC_GIE   = 7;
  localparam int CC_PEIE  = 6;
  localparam int CC_T0IE  = 5;
  localparam int CC_INTE  = 4;
  localparam int CC_RBIE  = 3;
  localparam int CC_T0IF  = 2;
  localparam int CC_EXT_IRQ_FLAG  = 1;
  localparam int CC_PORT_CHANGE_FLAG  = 0;
  localparam logic [7:0] CC_FLAG_MASK = 8'h07;

  // option register fields
  localparam int OPT_EDGE = 8;
  localparam int OPT_IOC_MSB = 7;

  // valid bits of the second peripheral flag and enable registers
  localparam logic [7:0] PREQ_TWO_MASK = 8'hFD;

  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_ZERO    = 13'h0000;
  localparam logic [12:0] PC_ONE     = 13'h0001;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ==========================================================================
  // sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_SYNC  = 4'b0010,
    ST_VEC   = 4'b0100,
    ST_SLEEP = 4'b1000
  } mic_state_t;

endpackage : mic_pkg

// [mic_sync.sv]
`timescale 1ns/1ps
module mic_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // three stages; output changes once stages two and three agree
  // ==========================================================================
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } mic_sync_t;

  mic_sync_t state_reg;
  mic_sync_t state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.out[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.out;

endmodule : mic_sync

// [test_mcu_interrupt_control.sv]
`timescale 1ns/1ps
module test_mcu_interrupt_control;
  logic        core_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rnd = 8'h4d;
  logic [31:0] s_axi_wdata = 32'h0000_0000, rdat;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_irq_pin = 1'b0;
  logic [7:0]  change_detect_port = 8'h00, periph_one_evt = 8'h00, periph_two_evt = 8'h00;
  logic        tmr0_ovf_evt = 1'b0, ret_from_irq = 1'b0, sleep_req = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic [12:0] pc_current, pc_load_value, stack_push_data, exp_pc;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        instr_cycle, instr_done, irq_request, pc_load, stack_push, core_wake;
  logic        core_asleep;
  int          errors = 0, checks_done = 0, exp_one, exp_two, ic;

  always #10 core_clk = ~core_clk;

  mic_irq_ctrl dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_irq_pin, .change_detect_port, .tmr0_ovf_evt,
    .periph_one_evt, .periph_two_evt, .instr_cycle, .instr_done, .ret_from_irq, .sleep_req,
    .pc_current, .irq_request, .pc_load, .pc_load_value, .stack_push, .stack_push_data,
    .core_wake, .core_asleep);

  mic_core_model core (.core_clk, .rst_n, .slow, .asleep(core_asleep), .pc_load,
    .pc_load_value, .instr_cycle, .instr_done, .pc_current);

  // ==========================================================
  // tasks
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  task automatic core_op(input logic sl);
    @(posedge core_clk);
    if (sl) sleep_req <= 1'b1;
    else ret_from_irq <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (!(instr_cycle === 1'b1 && instr_done === 1'b1));
    sleep_req <= 1'b0;
    ret_from_irq <= 1'b0;
  endtask : core_op

  task automatic wait_load;
    ic = 0;
    do begin
      @(posedge core_clk);
      if (instr_cycle === 1'b1) ic++;
    end while (pc_load !== 1'b1);
  endtask : wait_load

  task automatic test_done;
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    test_done();
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(mic_pkg::ADDR_CORE_CTRL);
    chk("core ctrl reset", rdat, 32'h0000_0000);
    rd(8'h20);
    chk("unmapped read", resp, mic_pkg::RESP_SLVERR);
    wr(mic_pkg::ADDR_STATUS, 32'h0000_0000, 4'h1);
    chk("unmapped write", resp, mic_pkg::RESP_SLVERR);
    rnd = lfsr(rnd);
    tmr0_ovf_evt <= 1'b1;
    periph_one_evt <= rnd;
    periph_two_evt <= ~rnd;
    @(posedge core_clk);
    tmr0_ovf_evt <= 1'b0;
    periph_one_evt <= 8'h00;
    periph_two_evt <= 8'h00;
    exp_one = rnd;
    exp_two = ~rnd & mic_pkg::PREQ_TWO_MASK;
    rd(mic_pkg::ADDR_CORE_CTRL);
    chk("t0 flag", rdat, 32'h0000_0004);
    rd(mic_pkg::ADDR_PREQ_ONE);
    chk("request one", rdat, exp_one);
    rd(mic_pkg::ADDR_PREQ_TWO);
    chk("request two", rdat, exp_two);
    wr(mic_pkg::ADDR_PEN_ONE, exp_one, 4'h1);
    chk("write resp", resp, mic_pkg::RESP_OKAY);
    wr(mic_pkg::ADDR_CORE_CTRL, 32'h0000_0044, 4'h1);
    repeat (20) @(posedge core_clk);
    chk("pending no gie", irq_request, 1'b0);
    wr(mic_pkg::ADDR_CORE_CTRL, 32'h0000_00c4, 4'h1);
    wait_load();
    chk("vector", pc_load_value, mic_pkg::IRQ_VECTOR);
    chk("push", stack_push, 1'b1);
    chk("return address", stack_push_data, pc_current);
    rd(mic_pkg::ADDR_CORE_CTRL);
    chk("gie cleared", rdat, 32'h0000_0044);
    wr(mic_pkg::ADDR_PREQ_ONE, 32'h0000_0000, 4'h1);
    wr(mic_pkg::ADDR_CORE_CTRL, 32'h0000_0040, 4'h1);
    core_op(1'b0);
    rd(mic_pkg::ADDR_CORE_CTRL);
    chk("gie after return", rdat, 32'h0000_00c0);
    chk("no reentry", irq_request, 1'b0);
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      wr(mic_pkg::ADDR_OPTION, {23'h0, ~i[0], 8'h00}, 4'h2);
      wr(mic_pkg::ADDR_CORE_CTRL, 32'h0000_0090, 4'h1);
      ext_irq_pin <= ~ext_irq_pin;
      wait_load();
      chk("ext latency", ic <= 4 && pc_load === 1'b1, 1'b1);
      rd(mic_pkg::ADDR_CORE_CTRL);
      chk("ext flag", rdat, 32'h0000_0012);
    end
    slow <= 1'b0;
    wr(mic_pkg::ADDR_CORE_CTRL, 32'h0000_0020, 4'h1);
    core_op(1'b1);
    repeat (3) @(posedge core_clk);
    chk("asleep", core_asleep, 1'b1);
    exp_pc = pc_current;
    tmr0_ovf_evt <= 1'b1;
    @(posedge core_clk);
    tmr0_ovf_evt <= 1'b0;
    wait_load();
    chk("wake pc", pc_load_value, exp_pc + 13'h0001);
    chk("wake no push", stack_push, 1'b0);
    chk("wake pulse", core_wake, 1'b1);
    rd(mic_pkg::ADDR_CORE_CTRL);
    chk("wake flag", rdat, 32'h0000_0024);
    wr(mic_pkg::ADDR_OPTION, 32'h0000_0001, 4'h1);
    rd(mic_pkg::ADDR_PORT);
    wr(mic_pkg::ADDR_CORE_CTRL, 32'h0000_0000, 4'h1);
    change_detect_port <= 8'h02;
    repeat (6) @(posedge core_clk);
    rd(mic_pkg::ADDR_CORE_CTRL);
    chk("masked pin", rdat, 32'h0000_0000);
    change_detect_port <= 8'h03;
    repeat (6) @(posedge core_clk);
    rd(mic_pkg::ADDR_CORE_CTRL);
    chk("change flag", rdat, 32'h0000_0001);
    test_done();
  end
endmodule : test_mcu_interrupt_control
